// file: qrs_pkg.sv
// Constants and carrier types for the quad recirculating shift register
//
// Contract
// - Four independent 80-bit serial lines, each with data in, out, select.
// - Select low loads external data; select high feeds the line output back.
// - One shared shift clock advances all four lines together.
// - While the shift clock is high the selected bit is taken in; the core takes the bit sampled with the first low clock.
// - After each falling edge shifting stops and the new output bit holds.
// - Each output equals the bit selected 80 shifts earlier, not inverted.
// - No data hold after the capturing edge, so outputs may feed inputs; the core needs data held until its first low clock sample.
package qrs_pkg;

    // ********************************************************
    // Geometry
    // ********************************************************
    localparam int LANE_COUNT  = 4;
    localparam int LANE_LENGTH = 80;
    localparam int FIFO_DEPTH  = 16;

    localparam logic [LANE_LENGTH-1:0] LANE_RESET  = '0;
    localparam logic [LANE_COUNT-1:0]  SYNC_RESET  = 4'h0;
    localparam logic [6:0]             LOAD_FULL   = 7'h50;
    localparam logic [6:0]             LOAD_RESET  = 7'h00;

    // ********************************************************
    // Driver timing limits
    // ********************************************************
    localparam int CLOCK_HZ      = 100_000_000;
    localparam int SHIFT_MIN_HZ  = 10_000;
    localparam int SHIFT_MAX_HZ  = 2_500_000;
    localparam int SHIFT_MIN_CYC = (CLOCK_HZ + SHIFT_MAX_HZ - 1) / SHIFT_MAX_HZ;

    // One sampled falling edge: data and select of every lane
    typedef struct packed {
        logic [LANE_COUNT-1:0] dataIn;
        logic [LANE_COUNT-1:0] recirc;
    } qrs_sample_s;

endpackage : qrs_pkg

// file: qrs_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module qrs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,    // System clock
    input  wire logic             rst,      // Async reset, active high
    input  wire logic [WIDTH-1:0] inData,   // Write word
    input  wire logic             inValid,  // Write request
    output logic                  inReady,  // Space available
    output logic      [WIDTH-1:0] outData,  // Head word
    output logic                  outValid, // Head word present
    input  wire logic             outReady  // Head word taken
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wrPtr;
    logic [AW-1:0]    next_rdPtr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        next_wrPtr = push ? wrPtr + AW'(1) : wrPtr;
        next_rdPtr = pop ? rdPtr + AW'(1) : rdPtr;
        next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    // Storage has no reset; a word is only read after it was written
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

endmodule : qrs_fifo

// file: qrs_shift_register.sv
// Quad 80-bit recirculating shift register core
`timescale 1ns/100ps
module qrs_shift_register
    import qrs_pkg::*;
(
    input  wire logic                  clock,        // 100 MHz system clock
    input  wire logic                  rst,          // Async reset, active high
    input  wire logic                  shiftClk,     // Shared shift clock pin
    input  wire logic [LANE_COUNT-1:0] dataIn,       // Serial data per lane
    input  wire logic [LANE_COUNT-1:0] recircSelect, // High recirculates lane
    input  wire logic                  holdShift,    // Stalls the shift engine
    output logic      [LANE_COUNT-1:0] dataOut,      // Serial output per lane
    output logic                       captureReady, // Edge buffer has room
    output logic                       primed        // 80 shifts since reset
);

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    logic        clkMeta;
    logic        clkSync;
    logic        clkLast;
    logic [LANE_COUNT-1:0] dataMeta;
    logic [LANE_COUNT-1:0] dataSync;
    logic [LANE_COUNT-1:0] selMeta;
    logic [LANE_COUNT-1:0] selSync;

    // Data and select travel through the same depth as the clock, so the value
    // seen at the detected edge is the one sampled with the first low clock: data must hold until then
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            clkMeta  <= 1'b0;
            clkSync  <= 1'b0;
            clkLast  <= 1'b0;
            dataMeta <= SYNC_RESET;
            dataSync <= SYNC_RESET;
            selMeta  <= SYNC_RESET;
            selSync  <= SYNC_RESET;
        end else begin
            clkMeta  <= shiftClk;
            clkSync  <= clkMeta;
            clkLast  <= clkSync;
            dataMeta <= dataIn;
            dataSync <= dataMeta;
            selMeta  <= recircSelect;
            selSync  <= selMeta;
        end
    end

    // ********************************************************
    // Edge capture into the buffer
    // ********************************************************
    logic        fallEdge;
    qrs_sample_s capWord;
    qrs_sample_s headWord;
    logic        headValid;
    logic        shiftEn;

    // Bits sampled with the first low clock are committed at its falling edge
    assign fallEdge        = clkLast && !clkSync;
    assign capWord.dataIn  = dataSync;
    assign capWord.recirc  = selSync;

    qrs_fifo #(
        .WIDTH ($bits(qrs_sample_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock    (clock),
        .rst      (rst),
        .inData   (capWord),
        .inValid  (fallEdge),
        .inReady  (captureReady),
        .outData  (headWord),
        .outValid (headValid),
        .outReady (!holdShift)
    );

    // One common enable for every lane
    assign shiftEn = headValid && !holdShift;

    // ********************************************************
    // Lanes
    // ********************************************************
    logic [LANE_LENGTH-1:0] lane      [LANE_COUNT];
    logic [LANE_LENGTH-1:0] next_lane [LANE_COUNT];
    logic [LANE_COUNT-1:0]  next_dataOut;

    // Lanes are zeroed for a clean simulation start only; callers must not
    // rely on this content before a full load
    genvar g;
    generate
        for (g = 0; g < LANE_COUNT; g++) begin : g_lane
            logic entry;
            always_comb begin
                entry = headWord.recirc[g] ? lane[g][LANE_LENGTH-1]
                                           : headWord.dataIn[g];
                next_lane[g]    = shiftEn ? {lane[g][LANE_LENGTH-2:0], entry}
                                          : lane[g];
                next_dataOut[g] = next_lane[g][LANE_LENGTH-1];
            end
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    lane[g] <= LANE_RESET;
                end else begin
                    lane[g] <= next_lane[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dataOut <= SYNC_RESET;
        end else begin
            dataOut <= next_dataOut;
        end
    end

    // ********************************************************
    // Load tracker
    // ********************************************************
    logic [6:0] loadCount;
    logic [6:0] next_loadCount;

    always_comb begin
        next_loadCount = loadCount;
        if (shiftEn && loadCount != LOAD_FULL) begin
            next_loadCount = loadCount + 7'h01;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            loadCount <= LOAD_RESET;
        end else begin
            loadCount <= next_loadCount;
        end
    end

    // Registered so the status pin cannot glitch while the count settles
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            primed <= 1'b0;
        end else begin
            primed <= (next_loadCount == LOAD_FULL);
        end
    end

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Pin-side checks assume pins move only at clock edges, as the bench
    // drives them; a truly asynchronous pin may land one cycle later
    a_edge_capture: assert property (
        fallEdge |-> $past(shiftClk, 3) && !$past(shiftClk, 2))
        else $error("capture without falling shift clock edge");

    a_no_hold_data: assert property (
        fallEdge |-> capWord.dataIn == $past(dataIn, 2))
        else $error("captured data not aligned with clock edge");

    a_select_align: assert property (
        fallEdge |-> capWord.recirc == $past(recircSelect, 2))
        else $error("captured select not aligned with clock edge");

    a_load_select: assert property (
        shiftEn && !headWord.recirc[0] |=> lane[0][0] == $past(headWord.dataIn[0]))
        else $error("external data not loaded into first stage");

    a_recirc_select: assert property (
        shiftEn && headWord.recirc[1] |=> lane[1][0] == $past(lane[1][LANE_LENGTH-1]))
        else $error("output not fed back on recirculate");

    a_common_shift: assert property (
        !shiftEn |=> lane[0] == $past(lane[0]) && lane[3] == $past(lane[3]))
        else $error("lane moved without common shift");

    a_hold_output: assert property (
        !shiftEn |=> $stable(dataOut))
        else $error("output changed between shifts");

    a_hold_queue: assert property (
        holdShift |-> !shiftEn)
        else $error("lanes shifted while stalled");

    a_true_delay: assert property (
        shiftEn |=> dataOut[2] == $past(lane[2][LANE_LENGTH-2]))
        else $error("output not the bit entered 80 shifts earlier");

    a_lane_step: assert property (
        shiftEn |=> lane[3][LANE_LENGTH-1:1] == $past(lane[3][LANE_LENGTH-2:0]))
        else $error("lane stages did not advance by one");

    a_lane_width: assert property (
        dataOut == {lane[3][LANE_LENGTH-1], lane[2][LANE_LENGTH-1],
                    lane[1][LANE_LENGTH-1], lane[0][LANE_LENGTH-1]})
        else $error("output does not tap the last stage");

    a_primed_count: assert property (
        shiftEn && loadCount == LOAD_FULL - 7'h01 |=> primed)
        else $error("primed not raised after 80 shifts");

    a_primed_hold: assert property (
        primed |=> primed)
        else $error("primed dropped without reset");

    a_count_idle: assert property (
        !shiftEn |=> $stable(loadCount))
        else $error("load count moved without a shift");

    c_recirculate: cover property (shiftEn && headWord.recirc == 4'hf);
    c_load_only:   cover property (shiftEn && headWord.recirc == 4'h0);
    c_fifo_full:   cover property (!captureReady);
    c_drain_burst: cover property (shiftEn ##1 shiftEn);
    c_primed:      cover property ($rose(primed));

endmodule : qrs_shift_register

// file: qrs_shift_driver.sv
// Model of the logic that clocks and feeds the shift register
`timescale 1ns/100ps
module qrs_shift_driver
    import qrs_pkg::*;
(
    input  wire logic                  clock,        // System clock
    input  wire logic                  go,           // Start one shift cycle
    input  wire logic [LANE_COUNT-1:0] bitIn,        // Data to present
    input  wire logic [LANE_COUNT-1:0] selIn,        // Selects to present
    output logic                       shiftClk,     // Shift clock pin
    output logic      [LANE_COUNT-1:0] dataIn,       // Data pins
    output logic      [LANE_COUNT-1:0] recircSelect, // Select pins
    output logic                       done          // Cycle finished
);
    initial begin
        shiftClk = 1'b0;
        dataIn = 4'h0;
        recircSelect = 4'h0;
        done = 1'b0;
        forever begin
            @(posedge clock);
            if (go) begin
                dataIn <= bitIn;
                recircSelect <= selIn;
                shiftClk <= 1'b1;
                repeat (20) @(posedge clock);
                shiftClk <= 1'b0;
                @(posedge clock);
                // Data moves one clock after the edge: one clock of hold is granted
                dataIn <= ~dataIn;
                repeat (19) @(posedge clock);
                done <= 1'b1;
                @(posedge clock);
                done <= 1'b0;
            end
        end
    end
endmodule : qrs_shift_driver

// file: testbench.sv
// Self-checking bench for the quad recirculating shift register
`timescale 1ns/100ps
module testbench;
    import qrs_pkg::*;
    logic                   clock = 1'b0;
    logic                   rst = 1'b1;
    logic                   go = 1'b0;
    logic                   holdShift = 1'b0;
    logic [LANE_COUNT-1:0]  bitIn = 4'h0;
    logic [LANE_COUNT-1:0]  selIn = 4'h0;
    logic [LANE_COUNT-1:0]  dataIn, recircSelect, dataOut, saved;
    logic                   shiftClk, done, captureReady, primed;
    logic [LANE_LENGTH-1:0] lane [LANE_COUNT];
    int                     shifts = 0;
    int                     failCount = 0;
    int                     testsRun = 0;
    int                     cycles = 0;

    always #5 clock = ~clock;

    qrs_shift_driver i_drv (.clock(clock), .go(go), .bitIn(bitIn), .selIn(selIn),
        .shiftClk(shiftClk), .dataIn(dataIn), .recircSelect(recircSelect), .done(done));

    qrs_shift_register i_dut (.clock(clock), .rst(rst), .shiftClk(shiftClk),
        .dataIn(dataIn), .recircSelect(recircSelect), .holdShift(holdShift),
        .dataOut(dataOut), .captureReady(captureReady), .primed(primed));

    // ****************************************************
    // Expectation and checking
    // ****************************************************
    function automatic logic [LANE_LENGTH-1:0] nextLane(logic [LANE_LENGTH-1:0] q,
                                                        logic d, logic s);
        return {q[LANE_LENGTH-2:0], s ? q[LANE_LENGTH-1] : d};
    endfunction : nextLane

    function automatic logic [LANE_COUNT-1:0] expOut();
        for (int i = 0; i < LANE_COUNT; i++) expOut[i] = lane[i][LANE_LENGTH-1];
    endfunction : expOut

    task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
        testsRun++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            failCount++;
        end
    endtask : check

    task automatic endSim();
        $display("Comparisons %0d, mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : endSim

    // One shift; a dropped edge leaves the model untouched
    task automatic doShift(input logic [3:0] d, input logic [3:0] s, input bit taken);
        int n;
        n = 0;
        go <= 1'b1;
        bitIn <= d;
        selIn <= s;
        @(posedge clock);
        go <= 1'b0;
        while (done !== 1'b1 && n < 100) begin
            @(posedge clock);
            n++;
        end
        if (done !== 1'b1) begin
            $display("CHECK FAILED done expected 1 seen %b", done);
            failCount++;
        end
        if (taken) begin
            for (int i = 0; i < LANE_COUNT; i++) lane[i] = nextLane(lane[i], d[i], s[i]);
            shifts++;
        end
        if (!holdShift) begin
            repeat (6) @(posedge clock);
            check("dataOut", expOut(), dataOut);
            check("primed", {3'h0, shifts >= LANE_LENGTH}, {3'h0, primed});
        end
    endtask : doShift

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failCount++;
            endSim();
        end
    end

    // ****************************************************
    // Scenarios
    // ****************************************************
    initial begin
        void'($urandom(32'h8e56));
        for (int i = 0; i < LANE_COUNT; i++) lane[i] = '0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        for (int k = 0; k < 100; k++) doShift(4'($urandom), 4'h0, 1'b1);
        for (int k = 0; k < 90; k++) doShift(4'($urandom), 4'($urandom), 1'b1);
        for (int k = 0; k < LANE_LENGTH; k++) doShift(4'($urandom), 4'hf, 1'b1);
        saved = dataOut;
        holdShift <= 1'b1;
        for (int k = 0; k < FIFO_DEPTH; k++) doShift(4'($urandom), 4'h5, 1'b1);
        check("heldOut", saved, dataOut);
        check("ready", 4'h0, {3'h0, captureReady});
        doShift(4'hf, 4'h0, 1'b0);
        holdShift <= 1'b0;
        repeat (40) @(posedge clock);
        check("drained", expOut(), dataOut);
        check("readyBack", 4'h1, {3'h0, captureReady});
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        check("rstPrimed", 4'h0, {3'h0, primed});
        rst <= 1'b0;
        for (int i = 0; i < LANE_COUNT; i++) lane[i] = '0;
        shifts = 0;
        for (int k = 0; k < 5; k++) doShift(4'($urandom), 4'h0, 1'b1);
        endSim();
    end
endmodule : testbench
